/* hw/ffs_pkg.sv */
// Types shared by the fault supervisor and its bench.
// Assumes comparator flags are active high levels from the analog side.
package ffs_pkg;

	// ----------------------------------------------------------------
	// Comparator and supply flags
	// ----------------------------------------------------------------
	typedef struct packed {
		logic fault_low;
		logic fault_release;
		logic fault_high;
		logic abn_current;
		logic normal_limit;
		logic overload;
		logic supply_overvoltage_threshold;
		logic die_overtemp;
		logic vcc_on;
		logic vcc_reset;
		logic line_removal;
		logic zcd_armed;
		logic demag;
	} ffs_flags_t;

	typedef enum logic [2:0] {
		ST_POWERUP, ST_SOFTSTART, ST_RUN, ST_AUTOREC, ST_NONLATCH, ST_LATCHED
	} ffs_state_t;

	typedef enum logic [2:0] {
		CAUSE_NONE, CAUSE_OTP, CAUSE_PIN_OVP, CAUSE_OVERLOAD, CAUSE_ABNORMAL_OVERCURRENT_FAULT,
		CAUSE_SUPPLY_OVERVOLTAGE_THRESHOLD, CAUSE_DIE_OT
	} ffs_cause_t;

endpackage

/* hw/ffs_regs.svh */
// Named offsets, fields, reset values and timing figures of the fault supervisor.
// Assumes a 40 MHz system clock; all cycle counts derive from it.
`ifndef FFS_REGS_SVH
`define FFS_REGS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define FFS_CLK_MHZ             40
`define FFS_CLK_KHZ             40000

// ----------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------
// Fault pin blanking delay, least time, rounds up
`define FFS_FAULT_BLANK_NS      30000
`define FFS_FAULT_BLANK_CYC     ((`FFS_FAULT_BLANK_NS * `FFS_CLK_MHZ + 999) / 1000)
// Abnormal overcurrent blanking, least time, rounds up
`define FFS_SHORT_BLANK_NS      125
`define FFS_SHORT_BLANK_CYC     ((`FFS_SHORT_BLANK_NS * `FFS_CLK_MHZ + 999) / 1000)
// Maximum on-time, longest time, rounds down
`define FFS_MAX_ON_NS           32000
`define FFS_MAX_ON_CYC          ((`FFS_MAX_ON_NS * `FFS_CLK_MHZ) / 1000)
// Overload integrator full duration
`define FFS_OVLD_MS             160
`define FFS_OVLD_CYC            (`FFS_OVLD_MS * `FFS_CLK_KHZ)
// Auto-recovery timer
`define FFS_AUTOREC_MS          1200
`define FFS_AUTOREC_CYC         (`FFS_AUTOREC_MS * `FFS_CLK_KHZ)

// ----------------------------------------------------------------
// Strike count and register map
// ----------------------------------------------------------------
`define FFS_ABNORMAL_OVERCURRENT_FAULT_STRIKES        3'h4
`define FFS_REG_CTRL            4'h0
`define FFS_REG_STATUS          4'h4
`define FFS_REG_OVLD            4'h8
`define FFS_CTRL_RESET          32'h0000_0002
`define FFS_CTRL_LATCH_BIT      0
`define FFS_CTRL_ENABLE_BIT     1
`define FFS_ST_STATE_LSB        0
`define FFS_ST_CAUSE_LSB        4
`define FFS_ST_ABNORMAL_OVERCURRENT_FAULT_LSB         8
`define FFS_ST_GATE_BIT         12
`define FFS_ST_BIAS_BIT         13

`endif

/* hw/ffs_supervisor.sv */
// Fault supervisor of a quasi-resonant flyback controller: gate drive gating,
// fault filters, overload integrator, strike counter and Avalon-MM registers.
// Assumes asynchronous comparator flags and a pulse request from the modulator
// on the same clock.
`include "ffs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ffs_supervisor #(
	parameter int unsigned     OVLD_CYCLES        = `FFS_OVLD_CYC,
	parameter int unsigned     AUTOREC_CYCLES     = `FFS_AUTOREC_CYC,
	parameter int unsigned     SOFTSTART_CYCLES   = 32'h0000_1000,
	parameter logic [15:0]     NORMAL_BLANK_CYCLES = 16'h000A,
	parameter logic [15:0]     VALLEY_TIMEOUT     = 16'h0100
) (
	input  wire logic              clock_in,
	input  wire logic              srst_in,
	input  wire ffs_pkg::ffs_flags_t comparator_flags_in,
	input  wire logic              pulse_request_in,
	output logic                   gate_drive_out,
	output logic                   otp_bias_enable_out,
	input  wire logic [3:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out
);
	import ffs_pkg::*;

	localparam int FLAG_W = $bits(ffs_flags_t);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [FLAG_W-1:0] sync_meta;
	logic [FLAG_W-1:0] sync_out;
	ffs_flags_t        flags;
	logic              vcc_on_d;
	logic              on_rise;

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_W; gi++) begin : g_sync
			always_ff @(posedge clock_in) begin
				if (srst_in) begin
					sync_meta[gi] <= 1'b0;
					sync_out[gi]  <= 1'b0;
				end else begin
					sync_meta[gi] <= comparator_flags_in[gi];
					sync_out[gi]  <= sync_meta[gi];
				end
			end
		end
	endgenerate

	assign flags = ffs_flags_t'(sync_out);

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			vcc_on_d <= 1'b0;
		end else begin
			vcc_on_d <= flags.vcc_on;
		end
	end

	assign on_rise = flags.vcc_on & ~vcc_on_d;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ffs_state_t  state;
	ffs_cause_t  cause;
	ffs_cause_t  trip_cause;
	logic        trip_latch;
	logic        trip;
	logic        active;
	logic        supply_clear;
	logic [31:0] ctrl;
	logic        latch_variant;
	logic        sw_enable;
	logic [1:0]  pin_raw;
	logic [1:0]  pin_fault;
	logic [15:0] pin_cnt [2];
	logic [31:0] ovld_cnt;
	logic [31:0] autorec_cnt;
	logic [31:0] ss_cnt;
	logic        ss_done;
	logic        autorec_done;
	logic [15:0] on_cnt;
	logic [15:0] valley_cnt;
	logic        demag_seen;
	logic        abnormal_overcurrent_fault_seen;
	logic        abnormal_overcurrent_fault_now;
	logic [2:0]  abnormal_overcurrent_fault_cnt;
	logic        pulse_end;
	logic        pulse_stop;
	logic        valley_ok;
	logic        ack;

	assign latch_variant = ctrl[`FFS_CTRL_LATCH_BIT];
	assign sw_enable     = ctrl[`FFS_CTRL_ENABLE_BIT];
	assign active        = (state == ST_SOFTSTART) | (state == ST_RUN);
	assign supply_clear  = flags.vcc_reset | flags.line_removal;

	// ----------------------------------------------------------------
	// Fault pin filters
	// ----------------------------------------------------------------
	// Low comparator masked outside run
	assign pin_raw = {flags.fault_high, flags.fault_low & (state == ST_RUN)};

	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			always_ff @(posedge clock_in) begin
				if (srst_in | ~pin_raw[gi]) begin
					pin_cnt[gi] <= 16'h0000;
				end else if (pin_cnt[gi] <= 16'(`FFS_FAULT_BLANK_CYC)) begin
					pin_cnt[gi] <= pin_cnt[gi] + 16'h0001;
				end
			end
			assign pin_fault[gi] = pin_cnt[gi] > 16'(`FFS_FAULT_BLANK_CYC);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Overload integrator
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in | supply_clear | ~active) begin
			ovld_cnt <= 32'h0000_0000;
		// Up while present, down when absent
		end else if (flags.overload) begin
			if (ovld_cnt < OVLD_CYCLES) begin
				ovld_cnt <= ovld_cnt + 32'h0000_0001;
			end
		end else if (ovld_cnt != 32'h0000_0000) begin
			ovld_cnt <= ovld_cnt - 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Fault priority
	// ----------------------------------------------------------------
	always_comb begin
		trip_cause = CAUSE_NONE;
		trip_latch = 1'b0;
		if (flags.supply_overvoltage_threshold) begin
			trip_cause = CAUSE_SUPPLY_OVERVOLTAGE_THRESHOLD;
			trip_latch = 1'b1;
		end else if (pin_fault[1]) begin
			trip_cause = CAUSE_PIN_OVP;
			trip_latch = 1'b1;
		end else if (abnormal_overcurrent_fault_cnt == `FFS_ABNORMAL_OVERCURRENT_FAULT_STRIKES) begin
			trip_cause = CAUSE_ABNORMAL_OVERCURRENT_FAULT;
			trip_latch = 1'b1;
		end else if (flags.die_overtemp) begin
			trip_cause = CAUSE_DIE_OT;
		end else if (pin_fault[0]) begin
			trip_cause = CAUSE_OTP;
			trip_latch = latch_variant;
		end else if (ovld_cnt == OVLD_CYCLES) begin
			trip_cause = CAUSE_OVERLOAD;
			trip_latch = latch_variant;
		end
	end

	assign trip = active & (trip_cause != CAUSE_NONE);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state <= ST_POWERUP;
		// Supply reset or line removal clears
		end else if (supply_clear) begin
			state <= ST_POWERUP;
		end else begin
			unique case (state)
				ST_POWERUP: begin
					if (flags.vcc_on) begin
						state <= ST_SOFTSTART;
					end
				end
				ST_SOFTSTART, ST_RUN: begin
					if (trip & trip_latch) begin
						state <= ST_LATCHED;
					end else if (trip & (trip_cause == CAUSE_DIE_OT)) begin
						state <= ST_NONLATCH;
					end else if (trip) begin
						state <= ST_AUTOREC;
					end else if (ss_done) begin
						state <= ST_RUN;
					end
				end
				ST_AUTOREC: begin
					if (autorec_done & on_rise &
					    ((cause != CAUSE_OTP) | flags.fault_release)) begin
						state <= ST_SOFTSTART;
					end
				end
				ST_NONLATCH: begin
					if (on_rise & ~flags.die_overtemp) begin
						state <= ST_SOFTSTART;
					end
				end
				ST_LATCHED: begin
					state <= ST_LATCHED;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in | supply_clear) begin
			cause <= CAUSE_NONE;
		end else if (trip) begin
			cause <= trip_cause;
		end
	end

	// ----------------------------------------------------------------
	// Soft-start and auto-recovery timers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in | (state != ST_SOFTSTART)) begin
			ss_cnt <= 32'h0000_0000;
		end else if (~ss_done) begin
			ss_cnt <= ss_cnt + 32'h0000_0001;
		end
	end

	assign ss_done = ss_cnt == SOFTSTART_CYCLES;

	always_ff @(posedge clock_in) begin
		if (srst_in | (state != ST_AUTOREC)) begin
			autorec_cnt <= 32'h0000_0000;
		end else if (~autorec_done) begin
			autorec_cnt <= autorec_cnt + 32'h0000_0001;
		end
	end

	assign autorec_done = autorec_cnt == AUTOREC_CYCLES;

	// ----------------------------------------------------------------
	// Thermistor bias
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			otp_bias_enable_out <= 1'b0;
		end else begin
			otp_bias_enable_out <= (state != ST_POWERUP) & ~supply_clear;
		end
	end

	// ----------------------------------------------------------------
	// Gate drive
	// ----------------------------------------------------------------
	// Max on-time ends pulse
	assign pulse_end  = (on_cnt == 16'(`FFS_MAX_ON_CYC - 1)) |
	                    (flags.normal_limit & (on_cnt >= NORMAL_BLANK_CYCLES));
	// Faults stop the pulse at once
	// Supply reset drops the gate with the bias, never after it
	assign pulse_stop = gate_drive_out &
	                    (pulse_end | trip | ~active | ~sw_enable | supply_clear);
	assign valley_ok  = demag_seen | (valley_cnt == VALLEY_TIMEOUT);

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			gate_drive_out <= 1'b0;
		end else if (pulse_stop) begin
			gate_drive_out <= 1'b0;
		end else if (~gate_drive_out & pulse_request_in & valley_ok & active &
		             sw_enable & ~trip & ~supply_clear) begin
			gate_drive_out <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in | ~gate_drive_out) begin
			on_cnt <= 16'h0000;
		end else begin
			on_cnt <= on_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in | gate_drive_out) begin
			demag_seen <= 1'b0;
		end else if (flags.demag) begin
			demag_seen <= 1'b1;
		end
	end

	// Timeout keeps the converter alive when no ringing arms the input
	always_ff @(posedge clock_in) begin
		if (srst_in | gate_drive_out | flags.zcd_armed) begin
			valley_cnt <= 16'h0000;
		end else if (valley_cnt != VALLEY_TIMEOUT) begin
			valley_cnt <= valley_cnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Abnormal overcurrent strikes
	// ----------------------------------------------------------------
	// Short blanking after turn-on
	assign abnormal_overcurrent_fault_now = gate_drive_out & flags.abn_current &
	                  (on_cnt >= 16'(`FFS_SHORT_BLANK_CYC));

	always_ff @(posedge clock_in) begin
		if (srst_in | ~gate_drive_out) begin
			abnormal_overcurrent_fault_seen <= 1'b0;
		end else if (abnormal_overcurrent_fault_now) begin
			abnormal_overcurrent_fault_seen <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in | supply_clear) begin
			abnormal_overcurrent_fault_cnt <= 3'h0;
		end else if (pulse_stop) begin
			if (abnormal_overcurrent_fault_seen | abnormal_overcurrent_fault_now) begin
				if (abnormal_overcurrent_fault_cnt != `FFS_ABNORMAL_OVERCURRENT_FAULT_STRIKES) begin
					abnormal_overcurrent_fault_cnt <= abnormal_overcurrent_fault_cnt + 3'h1;
				end
			end else begin
				abnormal_overcurrent_fault_cnt <= 3'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state
	// ----------------------------------------------------------------
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read_in | avs_write_in) & ~ack;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ctrl <= `FFS_CTRL_RESET;
		end else if (avs_write_in & ack & (avs_address_in == `FFS_REG_CTRL)) begin
			ctrl <= {30'h0000_0000, avs_writedata_in[1:0]};
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in & ~ack) begin
			avs_readdata_out <= 32'h0000_0000;
			unique case (avs_address_in)
				`FFS_REG_CTRL: begin
					avs_readdata_out <= ctrl;
				end
				`FFS_REG_STATUS: begin
					avs_readdata_out[`FFS_ST_STATE_LSB +: 3] <= 3'(state);
					avs_readdata_out[`FFS_ST_CAUSE_LSB +: 3] <= 3'(cause);
					avs_readdata_out[`FFS_ST_ABNORMAL_OVERCURRENT_FAULT_LSB +: 3]  <= abnormal_overcurrent_fault_cnt;
					avs_readdata_out[`FFS_ST_GATE_BIT]       <= gate_drive_out;
					avs_readdata_out[`FFS_ST_BIAS_BIT]       <= otp_bias_enable_out;
				end
				`FFS_REG_OVLD: begin
					avs_readdata_out <= ovld_cnt;
				end
				default: begin
					avs_readdata_out <= 32'h0000_0000;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* verif/ffs_analog_model.sv */
// Stand-in for the analog side: comparator flags and switch ringing.
// Assumes the bench sets the commanded fault levels in cmd_in.
`timescale 1ns/1ps
`default_nettype none
module ffs_analog_model (
	input  wire logic                clock_in,
	input  wire logic                gate_in,
	input  wire logic                bias_in,
	input  wire logic                slow_in,
	input  wire ffs_pkg::ffs_flags_t cmd_in,
	output var  ffs_pkg::ffs_flags_t flags_out
);
	import ffs_pkg::*;
	int ring;
	int charge;
	// Slow mode: demag lands well past the valley timeout
	always_ff @(posedge clock_in) begin
		if (gate_in) begin
			ring <= slow_in ? 403 : 15;
		end else if (ring > 0) begin
			ring <= ring - 1;
		end
	end
	// Filter cap keeps the pin low until the bias has charged it
	always_ff @(posedge clock_in) begin
		if (!bias_in) begin
			charge <= 0;
		end else if (charge < 10) begin
			charge <= charge + 1;
		end
	end
	always_comb begin
		flags_out = cmd_in;
		flags_out.fault_low = cmd_in.fault_low || charge < 10;
		flags_out.fault_release = !flags_out.fault_low;
		flags_out.abn_current = cmd_in.abn_current && gate_in;
		flags_out.zcd_armed = ring > 3;
		flags_out.demag = ring > 0 && ring < 4;
	end
endmodule
`default_nettype wire

/* verif/ffs_monitor.sv */
// Port checks for the fault supervisor.
// Bound into ffs_supervisor; sees its ports only.
`timescale 1ns/1ps
`include "ffs_regs.svh"
`default_nettype none
module ffs_monitor (
	input wire logic                clock_in,
	input wire logic                srst_in,
	input wire ffs_pkg::ffs_flags_t comparator_flags_in,
	input wire logic                pulse_request_in,
	input wire logic                gate_drive_out,
	input wire logic                otp_bias_enable_out,
	input wire logic [3:0]          avs_address_in,
	input wire logic                avs_read_in,
	input wire logic                avs_write_in,
	input wire logic [31:0]         avs_writedata_in,
	input wire logic [31:0]         avs_readdata_out,
	input wire logic                avs_waitrequest_out
);
	import ffs_pkg::*;
	localparam int MAX_ON = `FFS_MAX_ON_CYC;
	logic [15:0] high_run;
	// Gate-high cycles before the current one
	always_ff @(posedge clock_in) begin
		if (srst_in || !gate_drive_out) begin
			high_run <= 16'h0000;
		end else begin
			high_run <= high_run + 16'h0001;
		end
	end
	default clocking mon_cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);
	reset_idle_a: assert property ($fell(srst_in) |-> !gate_drive_out && !otp_bias_enable_out)
		else $error("gate or bias active after reset");
	bias_cause_a: assert property (
		$rose(otp_bias_enable_out) |-> $past(comparator_flags_in.vcc_on, 2))
		else $error("bias on without supply turn-on");
	max_on_a: assert property (gate_drive_out |-> high_run < MAX_ON)
		else $error("pulse past maximum on-time");
	gate_bias_a: assert property (gate_drive_out |-> otp_bias_enable_out)
		else $error("gate high before bias on");
	ovp_stop_a: assert property (comparator_flags_in.supply_overvoltage_threshold [*4] |-> !gate_drive_out)
		else $error("gate high during supply overvoltage");
	die_stop_a: assert property (comparator_flags_in.die_overtemp [*5] |-> !gate_drive_out)
		else $error("gate high during die overtemperature");
	supply_reset_a: assert property (
		(comparator_flags_in.vcc_reset || comparator_flags_in.line_removal) [*5]
		|-> !gate_drive_out && !otp_bias_enable_out) else $error("active during supply reset");
	valley_wait_a: assert property ($fell(gate_drive_out) ##1 comparator_flags_in.zcd_armed [*6]
		|-> !gate_drive_out) else $error("pulse started while zero crossing armed");
	bus_wait_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("wait state count wrong");
	unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 4'hC
		|-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* verif/ffs_supervisor_tb.sv */
// Self-checking bench for the fault supervisor.
// Assumes the analog model supplies the flags; the bench commands its levels.
`timescale 1ns/1ps
`include "ffs_regs.svh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %0h want %0h", $time, (g), (e)); end end
module ffs_supervisor_tb;
	import ffs_pkg::*;
	logic        clock_in, srst_in, req, slow, rd, wr, wreq, gate, bias;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, q;
	ffs_flags_t  cmd, flags;
	int          checked, n_mismatch, cyc, n, w;
	// Short timers keep the run brief; soft-start outlasts the pin filter
	ffs_supervisor #(.OVLD_CYCLES(50), .AUTOREC_CYCLES(40), .SOFTSTART_CYCLES(1500))
	ffs_supervisor_inst (
		.clock_in            (clock_in),
		.srst_in             (srst_in),
		.comparator_flags_in (flags),
		.pulse_request_in    (req),
		.gate_drive_out      (gate),
		.otp_bias_enable_out (bias),
		.avs_address_in      (addr),
		.avs_read_in         (rd),
		.avs_write_in        (wr),
		.avs_writedata_in    (wdata),
		.avs_readdata_out    (rdata),
		.avs_waitrequest_out (wreq)
	);
	ffs_analog_model ffs_analog_model_inst (.clock_in(clock_in), .gate_in(gate), .bias_in(bias),
		.slow_in(slow), .cmd_in(cmd), .flags_out(flags));
	task automatic end_of_test();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		rd <= !we;
		wr <= we;
		addr <= a;
		wdata <= d;
		// Held until waitrequest is sampled low; only the bench timeout ends a hang
		do begin
			@(posedge clock_in);
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic stat(input ffs_state_t s);
		bus(1'b0, `FFS_REG_STATUS, 32'h0000_0000);
		`CHK(q[2:0], s)
	endtask
	task automatic pulse();
		@(posedge clock_in);
		req <= 1'b1;
		n = 0;
		while (gate !== 1'b1) begin
			@(posedge clock_in);
			n++;
		end
		req <= 1'b0;
		w = 0;
		while (gate === 1'b1) begin
			@(posedge clock_in);
			w++;
		end
	endtask
	task automatic vcc_cycle();
		@(posedge clock_in);
		cmd.vcc_on <= 1'b0;
		repeat (4) @(posedge clock_in);
		cmd.vcc_on <= 1'b1;
		repeat (10) @(posedge clock_in);
	endtask
	task automatic power_up(input logic hot);
		cmd.fault_low <= hot;
		vcc_cycle();
		repeat (1290) @(posedge clock_in);
		stat(ST_SOFTSTART);
		cmd.fault_low <= 1'b0;
		repeat (250) @(posedge clock_in);
		stat(ST_RUN);
		`CHK(bias, 1'b1)
	endtask
	task automatic supply_reset(input logic line);
		@(posedge clock_in);
		cmd.vcc_on <= 1'b0;
		cmd.vcc_reset <= !line;
		cmd.line_removal <= line;
		repeat (8) @(posedge clock_in);
		cmd.vcc_reset <= 1'b0;
		cmd.line_removal <= 1'b0;
		repeat (4) @(posedge clock_in);
		stat(ST_POWERUP);
		`CHK(q[10:8], 3'h0)
		`CHK(bias, 1'b0)
		bus(1'b0, `FFS_REG_OVLD, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
	endtask
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc > 90000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		{srst_in, req, slow, rd, wr, addr, wdata, cmd} = '0;
		srst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		srst_in <= 1'b0;
		bus(1'b0, `FFS_REG_CTRL, 32'h0000_0000);
		`CHK(q, `FFS_CTRL_RESET)
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		bus(1'b1, `FFS_REG_CTRL, 32'hFFFF_FFFF);
		bus(1'b0, `FFS_REG_CTRL, 32'h0000_0000);
		`CHK(q, 32'h0000_0003)
		bus(1'b1, `FFS_REG_CTRL, `FFS_CTRL_RESET);
		`CHK(bias, 1'b0)
		power_up(1'b1);
		pulse();
		`CHK(w, `FFS_MAX_ON_CYC)
		slow <= 1'b1;
		pulse();
		slow <= 1'b0;
		pulse();
		`CHK(n >= 390, 1'b1)
		// Strike counter: three strikes, clean pulse, then four
		cmd.abn_current <= 1'b1;
		for (int i = 0; i < 3; i++) pulse();
		stat(ST_RUN);
		`CHK(q[10:8], 3'h3)
		cmd.abn_current <= 1'b0;
		pulse();
		stat(ST_RUN);
		`CHK(q[10:8], 3'h0)
		// Normal limit ends the pulse; short blanking still sees the strike
		cmd.abn_current <= 1'b1;
		cmd.normal_limit <= 1'b1;
		pulse();
		`CHK(w, 11)
		cmd.normal_limit <= 1'b0;
		stat(ST_RUN);
		`CHK(q[10:8], 3'h1)
		for (int i = 0; i < 3; i++) pulse();
		cmd.abn_current <= 1'b0;
		stat(ST_LATCHED);
		`CHK(q[6:4], CAUSE_ABNORMAL_OVERCURRENT_FAULT)
		vcc_cycle();
		stat(ST_LATCHED);
		supply_reset(1'b0);
		// Overload integrates across a gap
		power_up(1'b0);
		cmd.overload <= 1'b1;
		repeat (40) @(posedge clock_in);
		cmd.overload <= 1'b0;
		repeat (10) @(posedge clock_in);
		cmd.overload <= 1'b1;
		repeat (30) @(posedge clock_in);
		cmd.overload <= 1'b0;
		stat(ST_AUTOREC);
		`CHK(q[6:4], CAUSE_OVERLOAD)
		vcc_cycle();
		stat(ST_AUTOREC);
		repeat (40) @(posedge clock_in);
		power_up(1'b0);
		bus(1'b1, `FFS_REG_CTRL, 32'h0000_0003);
		cmd.overload <= 1'b1;
		repeat (80) @(posedge clock_in);
		cmd.overload <= 1'b0;
		stat(ST_LATCHED);
		supply_reset(1'b1);
		// Lower pin fault in both variants, latching first
		for (int v = 3; v > 1; v--) begin
			bus(1'b1, `FFS_REG_CTRL, 32'(v));
			power_up(1'b0);
			cmd.fault_low <= 1'b1;
			repeat (1000) @(posedge clock_in);
			cmd.fault_low <= 1'b0;
			stat(ST_RUN);
			cmd.fault_low <= 1'b1;
			repeat (1300) @(posedge clock_in);
			stat(v == 3 ? ST_LATCHED : ST_AUTOREC);
			`CHK(q[6:4], CAUSE_OTP)
			if (v == 2) begin
				// Timer long expired; restart still waits for pin release
				repeat (50) @(posedge clock_in);
				vcc_cycle();
				stat(ST_AUTOREC);
				cmd.fault_low <= 1'b0;
				vcc_cycle();
				stat(ST_SOFTSTART);
			end
			cmd.fault_low <= 1'b0;
			supply_reset(1'b0);
		end
		power_up(1'b0);
		cmd.die_overtemp <= 1'b1;
		repeat (10) @(posedge clock_in);
		stat(ST_NONLATCH);
		`CHK(q[6:4], CAUSE_DIE_OT)
		vcc_cycle();
		stat(ST_NONLATCH);
		cmd.die_overtemp <= 1'b0;
		power_up(1'b0);
		cmd.die_overtemp <= 1'b1;
		repeat (10) @(posedge clock_in);
		supply_reset(1'b1);
		cmd.die_overtemp <= 1'b0;
		power_up(1'b0);
		cmd.supply_overvoltage_threshold <= 1'b1;
		repeat (10) @(posedge clock_in);
		stat(ST_LATCHED);
		`CHK(q[6:4], CAUSE_SUPPLY_OVERVOLTAGE_THRESHOLD)
		cmd.supply_overvoltage_threshold <= 1'b0;
		supply_reset(1'b0);
		// Upper pin fault latches once held past the filter
		power_up(1'b0);
		cmd.fault_high <= 1'b1;
		repeat (1300) @(posedge clock_in);
		stat(ST_LATCHED);
		`CHK(q[6:4], CAUSE_PIN_OVP)
		cmd.fault_high <= 1'b0;
		supply_reset(1'b1);
		end_of_test();
	end
endmodule
bind ffs_supervisor ffs_monitor ffs_monitor_inst (.clock_in(clock_in), .srst_in(srst_in),
	.comparator_flags_in(comparator_flags_in), .pulse_request_in(pulse_request_in),
	.gate_drive_out(gate_drive_out), .otp_bias_enable_out(otp_bias_enable_out),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out));
`default_nettype wire
